// file: rtl/dcc_pkg.sv
// Purpose: Shared constants, types and decode helpers for the channel config block
// Assumes: Byte address of a register is four times its index
// Notes:   Index values are kept as printed; reset values as listed

package dcc_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int DCC_CHANNELS = 3;
  localparam int DCC_IDX_W    = 6;
  localparam int DCC_ADDR_W   = 8;
  localparam int DCC_DATA_W   = 32;
  localparam int DCC_CC_W     = 6;
  localparam int DCC_JA_W     = 5;
  localparam int DCC_STAT_W   = 8;
  localparam int DCC_JA_DEPTH = 16;

  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [DCC_IDX_W-1:0] DCC_CC_IDX [DCC_CHANNELS] = '{6'h06, 6'h0E, 6'h16};
  localparam logic [DCC_IDX_W-1:0] DCC_JA_IDX [DCC_CHANNELS] = '{6'h07, 6'h0F, 6'h17};
  localparam logic [DCC_IDX_W-1:0] DCC_STATUS_IDX            = 6'h20;

  // ----------------------------------------------------------------
  // Channel control fields
  // ----------------------------------------------------------------
  localparam int DCC_CC_SINGLE_RAIL = 0;
  localparam int DCC_CC_STS1        = 1;
  localparam int DCC_CC_E3          = 2;
  localparam int DCC_CC_LOCAL_LB    = 3;
  localparam int DCC_CC_REMOTE_LB   = 4;
  localparam int DCC_CC_PRBS        = 5;
  localparam logic [DCC_CC_W-1:0] DCC_CC_RESET = 6'h00;

  // ----------------------------------------------------------------
  // Jitter attenuator control fields
  // ----------------------------------------------------------------
  localparam int DCC_JA_LOW     = 0;
  localparam int DCC_JA_TX_PATH = 1;
  localparam int DCC_JA_HIGH    = 2;
  localparam int DCC_JA_HOLD    = 3;
  localparam int DCC_JA_APS_DIS = 4;
  localparam logic [DCC_JA_W-1:0] DCC_JA_RESET = 5'h01;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DCC_RATE_DS3  = 2'h0,
    DCC_RATE_STS1 = 2'h1,
    DCC_RATE_E3   = 2'h3
  } dcc_rate_e;

  typedef struct packed {
    logic      ja_hold;
    logic      ja_enable;
    logic      ja_desync;
    logic      ja_tx_path;
    logic      single_rail;
    dcc_rate_e rate;
  } dcc_cfg_s;

  localparam int DCC_CFG_W = $bits(dcc_cfg_s);

  typedef struct packed {
    logic pos;
    logic neg;
  } dcc_line_s;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic dcc_rate_e dcc_rate_decode(input logic e3, input logic sts1);
    if (e3) begin
      return DCC_RATE_E3;
    end
    if (sts1) begin
      return DCC_RATE_STS1;
    end
    return DCC_RATE_DS3;
  endfunction : dcc_rate_decode

  function automatic logic dcc_ja_desync(input logic low_bit, input logic high_bit);
    return low_bit & ~high_bit;
  endfunction : dcc_ja_desync

endpackage : dcc_pkg

// file: rtl/dcc_sync.sv
// Purpose: Two flip-flop level synchroniser
// Assumes: Input levels change slowly against the destination clock
// Notes:   First stage feeds only the second

`timescale 1ns/1ps

module dcc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Levels
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage <= RESET_VAL;
      dout  <= RESET_VAL;
    end else begin
      stage <= din;
      dout  <= stage;
    end
  end

endmodule : dcc_sync

// file: rtl/dcc_tx_chan.sv
// Purpose: Transmit path of one channel on its gapped transmit clock
// Assumes: Configuration is quasi-static while traffic runs
// Notes:   Logic advances only on clock pulses; gaps simply hold state

`timescale 1ns/1ps

module dcc_tx_chan #(
  parameter int JA_DEPTH = dcc_pkg::DCC_JA_DEPTH
) (
  // Link clock and reset
  input  wire logic              tx_clock_in,
  input  wire logic              presetn,
  // Mapper data
  input  wire logic              tx_positive_data_in,
  input  wire logic              tx_negative_data_in,
  // Configuration from the register domain
  input  wire dcc_pkg::dcc_cfg_s cfg,
  // Line pulses
  output dcc_pkg::dcc_line_s     line
);

  // ----------------------------------------------------------------
  // Configuration crossing
  // ----------------------------------------------------------------
  logic [dcc_pkg::DCC_CFG_W-1:0] cfg_bits;
  dcc_pkg::dcc_cfg_s             cfg_l;

  dcc_sync #(.WIDTH(dcc_pkg::DCC_CFG_W)) u_cfg_sync (
    .clk   (tx_clock_in),
    .rst_n (presetn),
    .din   (cfg),
    .dout  (cfg_bits)
  );

  assign cfg_l = dcc_pkg::dcc_cfg_s'(cfg_bits);

  // ----------------------------------------------------------------
  // Sampling and attenuator delay
  // ----------------------------------------------------------------
  logic                samp_pos;
  logic                samp_neg;
  logic [JA_DEPTH-1:0] ja_pos;
  logic [JA_DEPTH-1:0] ja_neg;
  logic                ja_active;
  logic                path_pos;
  logic                path_neg;
  logic                ami_phase;

  // Only bits under a clock edge are taken; gap data never lands
  always_ff @(posedge tx_clock_in or negedge presetn) begin
    if (!presetn) begin
      samp_pos <= 1'b0;
      samp_neg <= 1'b0;
    end else begin
      samp_pos <= tx_positive_data_in;
      samp_neg <= tx_negative_data_in & ~cfg_l.single_rail;
    end
  end

  assign ja_active = cfg_l.ja_enable & cfg_l.ja_tx_path & ~cfg_l.ja_hold;

  always_ff @(posedge tx_clock_in or negedge presetn) begin
    if (!presetn) begin
      ja_pos <= '0;
      ja_neg <= '0;
    end else begin
      ja_pos <= {ja_pos[JA_DEPTH-2:0], samp_pos};
      ja_neg <= {ja_neg[JA_DEPTH-2:0], samp_neg};
    end
  end

  assign path_pos = ja_active ? ja_pos[JA_DEPTH-1] : samp_pos;
  assign path_neg = ja_active ? ja_neg[JA_DEPTH-1] : samp_neg;

  // ----------------------------------------------------------------
  // Line encoding
  // ----------------------------------------------------------------
  // Single rail: ones alternate polarity; dual rail passes each rail only while the other rail is low
  always_ff @(posedge tx_clock_in or negedge presetn) begin
    if (!presetn) begin
      ami_phase <= 1'b0;
      line      <= '0;
    end else if (cfg_l.single_rail) begin
      ami_phase <= ami_phase ^ path_pos;
      line.pos  <= path_pos & ~ami_phase;
      line.neg  <= path_pos & ami_phase;
    end else begin
      ami_phase <= 1'b0;
      line.pos  <= path_pos & ~path_neg;
      line.neg  <= path_neg & ~path_pos;
    end
  end

endmodule : dcc_tx_chan

// file: rtl/dcc_top.sv
// Purpose: Per-channel rate, rail and attenuator configuration with transmit paths
// Assumes: APB master; host or hardware mode chosen by a strap pin
// Notes:   Register byte address is four times the register index
//
// Function
// - Sample each bit on gapped clock edge
// - Attenuate then encode line pulses
// - Host: both rate bits clear gives DS3
// - Hardware: both rate pins low gives DS3
// - Host: single-rail bit selects one data line
// - Hardware: single-rail pin high selects it
// - Host: D2 clear, D0 set gives de-sync
// - Host: D1 places enabled attenuator in transmit path while D3 clear
//
// The APB slave port was chosen for this implementation.

`timescale 1ns/1ps

module dcc_top #(
  parameter int CHANNELS = dcc_pkg::DCC_CHANNELS,
  parameter int JA_DEPTH = dcc_pkg::DCC_JA_DEPTH
) (
  // APB
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [dcc_pkg::DCC_ADDR_W-1:0]  paddr,
  input  wire logic [dcc_pkg::DCC_DATA_W-1:0]  pwdata,
  output logic      [dcc_pkg::DCC_DATA_W-1:0]  prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  // Hardware mode straps
  input  wire logic                            host_mode_select,
  input  wire logic [CHANNELS-1:0]             e3_rate_select,
  input  wire logic [CHANNELS-1:0]             sts1_versus_ds3_select,
  input  wire logic [CHANNELS-1:0]             single_rail_select,
  input  wire logic [CHANNELS-1:0]             jitter_control_low_bit,
  input  wire logic [CHANNELS-1:0]             jitter_control_high_bit,
  input  wire logic [CHANNELS-1:0]             jitter_path_tx_select,
  // Mapper transmit inputs
  input  wire logic [CHANNELS-1:0]             tx_clock_in,
  input  wire logic [CHANNELS-1:0]             tx_positive_data_in,
  input  wire logic [CHANNELS-1:0]             tx_negative_data_in,
  // Line outputs
  output dcc_pkg::dcc_line_s [CHANNELS-1:0]    line_out
);

  // ----------------------------------------------------------------
  // Strap synchronisation
  // ----------------------------------------------------------------
  localparam int PIN_W = 1 + 6 * CHANNELS;

  logic [PIN_W-1:0]    pin_raw;
  logic [PIN_W-1:0]    pin_sync;
  logic                host_mode;
  logic [CHANNELS-1:0] hw_e3;
  logic [CHANNELS-1:0] hw_sts1;
  logic [CHANNELS-1:0] hw_single;
  logic [CHANNELS-1:0] hw_ja_low;
  logic [CHANNELS-1:0] hw_ja_high;
  logic [CHANNELS-1:0] hw_ja_tx;

  assign pin_raw = {host_mode_select, e3_rate_select, sts1_versus_ds3_select,
                    single_rail_select, jitter_control_low_bit,
                    jitter_control_high_bit, jitter_path_tx_select};

  dcc_sync #(.WIDTH(PIN_W)) u_pin_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .din   (pin_raw),
    .dout  (pin_sync)
  );

  assign {host_mode, hw_e3, hw_sts1, hw_single, hw_ja_low, hw_ja_high, hw_ja_tx} = pin_sync;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic [dcc_pkg::DCC_IDX_W-1:0] acc_idx;
  logic                          setup;
  logic                          wr_en;
  logic [CHANNELS-1:0]           hit_cc;
  logic [CHANNELS-1:0]           hit_ja;
  logic                          hit_status;
  logic                          hit_any;
  logic                          aligned;

  assign acc_idx    = paddr[dcc_pkg::DCC_ADDR_W-1:2];
  assign aligned    = (paddr[1:0] == 2'h0);
  assign setup      = psel & ~penable;
  assign wr_en      = psel & penable & pready & pwrite;
  assign hit_status = aligned & (acc_idx == dcc_pkg::DCC_STATUS_IDX);
  assign hit_any    = (|hit_cc) | (|hit_ja) | hit_status;

  // ----------------------------------------------------------------
  // Per-channel registers and effective configuration
  // ----------------------------------------------------------------
  logic [dcc_pkg::DCC_CC_W-1:0]   chan_line_control [CHANNELS];
  logic [dcc_pkg::DCC_JA_W-1:0]   chan_ja_control   [CHANNELS];
  dcc_pkg::dcc_cfg_s              host_cfg          [CHANNELS];
  dcc_pkg::dcc_cfg_s              hw_cfg            [CHANNELS];
  dcc_pkg::dcc_cfg_s              eff_cfg           [CHANNELS];
  logic [dcc_pkg::DCC_STAT_W-1:0] chan_status       [CHANNELS];

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
      assign hit_cc[ch] = aligned & (acc_idx == dcc_pkg::DCC_CC_IDX[ch]);
      assign hit_ja[ch] = aligned & (acc_idx == dcc_pkg::DCC_JA_IDX[ch]);

      // Each channel owns its own pair of registers
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          chan_line_control[ch] <= dcc_pkg::DCC_CC_RESET;
          chan_ja_control[ch]   <= dcc_pkg::DCC_JA_RESET;
        end else begin
          if (wr_en && hit_cc[ch]) begin
            chan_line_control[ch] <= pwdata[dcc_pkg::DCC_CC_W-1:0];
          end
          if (wr_en && hit_ja[ch]) begin
            chan_ja_control[ch] <= pwdata[dcc_pkg::DCC_JA_W-1:0];
          end
        end
      end

      // Host mode view of the registers
      assign host_cfg[ch].rate = dcc_pkg::dcc_rate_decode(
               chan_line_control[ch][dcc_pkg::DCC_CC_E3],
               chan_line_control[ch][dcc_pkg::DCC_CC_STS1]);
      assign host_cfg[ch].single_rail =
               chan_line_control[ch][dcc_pkg::DCC_CC_SINGLE_RAIL];
      assign host_cfg[ch].ja_desync = dcc_pkg::dcc_ja_desync(
               chan_ja_control[ch][dcc_pkg::DCC_JA_LOW],
               chan_ja_control[ch][dcc_pkg::DCC_JA_HIGH]);
      assign host_cfg[ch].ja_enable =
               chan_ja_control[ch][dcc_pkg::DCC_JA_LOW] |
               chan_ja_control[ch][dcc_pkg::DCC_JA_HIGH];
      assign host_cfg[ch].ja_tx_path =
               chan_ja_control[ch][dcc_pkg::DCC_JA_TX_PATH];
      assign host_cfg[ch].ja_hold = chan_ja_control[ch][dcc_pkg::DCC_JA_HOLD];

      // Hardware mode view of the straps
      assign hw_cfg[ch].rate = dcc_pkg::dcc_rate_decode(hw_e3[ch], hw_sts1[ch]);
      assign hw_cfg[ch].single_rail = hw_single[ch];
      assign hw_cfg[ch].ja_desync   = dcc_pkg::dcc_ja_desync(hw_ja_low[ch], hw_ja_high[ch]);
      assign hw_cfg[ch].ja_enable   = hw_ja_low[ch] | hw_ja_high[ch];
      assign hw_cfg[ch].ja_tx_path  = hw_ja_tx[ch];
      assign hw_cfg[ch].ja_hold     = 1'b0;

      assign eff_cfg[ch] = host_mode ? host_cfg[ch] : hw_cfg[ch];

      assign chan_status[ch] = dcc_pkg::DCC_STAT_W'(eff_cfg[ch]);

      dcc_tx_chan #(.JA_DEPTH(JA_DEPTH)) u_tx (
        .tx_clock_in         (tx_clock_in[ch]),
        .presetn             (presetn),
        .tx_positive_data_in (tx_positive_data_in[ch]),
        .tx_negative_data_in (tx_negative_data_in[ch]),
        .cfg                 (eff_cfg[ch]),
        .line                (line_out[ch])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read data selection
  // ----------------------------------------------------------------
  logic [dcc_pkg::DCC_DATA_W-1:0] rd_sel;
  logic [dcc_pkg::DCC_DATA_W-1:0] status_word;

  always_comb begin
    status_word = '0;
    for (int i = 0; i < CHANNELS; i++) begin
      status_word[i*dcc_pkg::DCC_STAT_W +: dcc_pkg::DCC_STAT_W] = chan_status[i];
    end
    status_word[dcc_pkg::DCC_DATA_W-1] = host_mode;
  end

  always_comb begin
    rd_sel = '0;
    for (int i = 0; i < CHANNELS; i++) begin
      if (hit_cc[i]) begin
        rd_sel = dcc_pkg::DCC_DATA_W'(chan_line_control[i]);
      end
      if (hit_ja[i]) begin
        rd_sel = dcc_pkg::DCC_DATA_W'(chan_ja_control[i]);
      end
    end
    if (hit_status) begin
      rd_sel = status_word;
    end
  end

  // ----------------------------------------------------------------
  // APB response: one access cycle, error on unmapped address
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit_any;
      if (setup && !pwrite) begin
        prdata <= rd_sel;
      end
    end
  end

endmodule : dcc_top

// file: tb/dcc_top_sva.sv
// Purpose: Port-level checks of the channel config block
// Assumes: Bound into dcc_top
// Notes:   Pulse-to-bit link check armed only in a settled hardware bypass on channel 0
`timescale 1ns/1ps
module dcc_top_sva #(
  parameter int CHANNELS = dcc_pkg::DCC_CHANNELS,
  parameter int JA_DEPTH = dcc_pkg::DCC_JA_DEPTH
) (
  // APB
  input wire logic                              pclk,
  input wire logic                              presetn,
  input wire logic                              psel,
  input wire logic                              penable,
  input wire logic                              pwrite,
  input wire logic [dcc_pkg::DCC_ADDR_W-1:0]    paddr,
  input wire logic [dcc_pkg::DCC_DATA_W-1:0]    prdata,
  input wire logic                              pready,
  input wire logic                              pslverr,
  // Straps and link
  input wire logic                              host_mode_select,
  input wire logic [CHANNELS-1:0]               single_rail_select,
  input wire logic [CHANNELS-1:0]               jitter_path_tx_select,
  input wire logic [CHANNELS-1:0]               tx_clock_in,
  input wire logic [CHANNELS-1:0]               tx_positive_data_in,
  input wire dcc_pkg::dcc_line_s [CHANNELS-1:0] line_out
);
  // ---------------------------------------------------------------
  // Pulses seen in a settled hardware bypass setup
  // ---------------------------------------------------------------
  logic [3:0] settle;
  wire        hw_bypass = !host_mode_select && single_rail_select[0] && !jitter_path_tx_select[0];
  always_ff @(posedge tx_clock_in[0] or negedge presetn) begin
    if (!presetn) settle <= 4'h0;
    else if (!hw_bypass) settle <= 4'h0;
    else if (settle != 4'hF) settle <= settle + 4'h1;
  end

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_bad_setup;
    psel && !penable && (paddr[1:0] != 2'h0);
  endsequence

  a_ready_after_setup: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup |=> pready) else $error("pready missing after setup");
  a_ready_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready) else $error("pready longer than one cycle");
  a_error_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready) else $error("pslverr without pready");
  a_misaligned_error: assert property (@(posedge pclk) disable iff (!presetn)
    s_bad_setup |=> pslverr) else $error("misaligned access not refused");
  a_error_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
    pready && pslverr && !pwrite |-> prdata == '0) else $error("refused read data not zero");
  a_read_data_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(pready && !pwrite) |-> $stable(prdata)) else $error("prdata moved outside a read");
  a_rail_exclusive: assert property (@(posedge tx_clock_in[0]) disable iff (!presetn)
    !(line_out[0].pos && line_out[0].neg)) else $error("both rails driven");
  a_hw_single_rail: assert property (@(posedge tx_clock_in[0]) disable iff (!presetn)
    settle == 4'hF |-> ((line_out[0] != 2'b00) == $past(tx_positive_data_in[0], 2)))
    else $error("line pulse not tied to sampled bit");
endmodule : dcc_top_sva

bind dcc_top dcc_top_sva #(.CHANNELS(CHANNELS), .JA_DEPTH(JA_DEPTH)) u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .host_mode_select(host_mode_select), .single_rail_select(single_rail_select),
  .jitter_path_tx_select(jitter_path_tx_select), .tx_clock_in(tx_clock_in),
  .tx_positive_data_in(tx_positive_data_in), .line_out(line_out));

// file: tb/dcc_mapper_model.sv
// Purpose: Mapper side of one channel: gapped clock and data
// Assumes: 15 ns slots, clock still between frames
// Notes:   Every fourth slot is overhead with no edge and the data line toggled
`timescale 1ns/1ps
module dcc_mapper_model (
  // Gapped clock and data
  output logic tx_clk,
  output logic tx_data
);
  initial begin
    tx_clk = 1'b0;
    tx_data = 1'b0;
  end
  task automatic send(input logic [31:0] bits);
    int i;
    int n;
    n = 0;
    for (i = 0; n < 32; i++) begin
      if (i % 4 == 3) begin
        tx_data = ~tx_data;
        #15;
      end else begin
        tx_data = bits[n];
        n++;
        #4 tx_clk = 1'b1;
        #7.5 tx_clk = 1'b0;
        #3.5;
      end
    end
  endtask : send
endmodule : dcc_mapper_model

// file: tb/tb_top.sv
// Purpose: Register, strap and gapped link tests of the channel config block
// Assumes: APB master at pclk, three mapper models
// Notes:   Attenuator depth reduced to keep link runs short
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin bad_count++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end
module tb_top;
  localparam int JAD = 4;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, host;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0] e3, sts, sr, jl, jh, jtx, neg;
  wire [2:0] txc, txd;
  dcc_pkg::dcc_line_s [2:0] line_out;
  dcc_pkg::dcc_line_s obs [3][$];
  logic [7:0] st_exp [3];
  logic [5:0] cc_t [4] = '{6'h00, 6'h03, 6'h04, 6'h3E};
  logic [4:0] ja_t [4] = '{5'h01, 5'h03, 5'h05, 5'h1A};
  int bad_count, samples_checked;

  dcc_top #(.CHANNELS(3), .JA_DEPTH(JAD)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .host_mode_select(host),
    .e3_rate_select(e3), .sts1_versus_ds3_select(sts), .single_rail_select(sr),
    .jitter_control_low_bit(jl), .jitter_control_high_bit(jh), .jitter_path_tx_select(jtx),
    .tx_clock_in(txc), .tx_positive_data_in(txd), .tx_negative_data_in(neg),
    .line_out(line_out));

  for (genvar g = 0; g < 3; g++) begin : g_ch
    dcc_mapper_model u_map (.tx_clk(txc[g]), .tx_data(txd[g]));
    always @(posedge txc[g]) obs[g].push_back(line_out[g]);
  end

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    `CHK("read data", exp, r)
    `CHK("read error", 1'b0, e)
  endtask : rd_chk

  function automatic logic [7:0] sbyte(input logic [2:0] cc, input logic [4:0] ja);
    logic [1:0] rt;
    rt = cc[2] ? 2'h3 : (cc[1] ? 2'h1 : 2'h0);
    return {1'b0, ja[3], ja[0] | ja[2], ja[0] & ~ja[2], ja[1], cc[0], rt};
  endfunction : sbyte

  function automatic logic [7:0] cca(input int c);
    return {dcc_pkg::DCC_CC_IDX[c], 2'b00};
  endfunction : cca

  function automatic logic [7:0] jaa(input int c);
    return {dcc_pkg::DCC_JA_IDX[c], 2'b00};
  endfunction : jaa

  task automatic chk_status();
    rd_chk({dcc_pkg::DCC_STATUS_IDX, 2'b00}, {host, 7'h00, st_exp[2], st_exp[1], st_exp[0]});
  endtask : chk_status

  task automatic run_link(input logic [4:0] ja, input int lat, input logic [2:0] mask);
    logic [31:0] bits;
    int c;
    int k;
    logic one;
    logic b;
    dcc_pkg::dcc_line_s e;
    bits = 32'h9E3C5A70;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (c = 0; c < 3 && host; c++) begin
      wr(cca(c), 32'h01);
      wr(jaa(c), {27'h0, ja});
    end
    repeat (4) @(posedge pclk);
    // Zero bits carry the settings across to the link side first
    fork
      g_ch[0].u_map.send(32'h0);
      g_ch[1].u_map.send(32'h0);
      g_ch[2].u_map.send(32'h0);
    join
    for (c = 0; c < 3; c++) obs[c].delete();
    fork
      g_ch[0].u_map.send(bits);
      g_ch[1].u_map.send(bits);
      g_ch[2].u_map.send(~bits & 32'hFFFFFFF0);
    join
    for (c = 0; c < 3; c++) begin
      one = 1'b0;
      if (mask[c]) `CHK("pulses", 32, obs[c].size())
      for (k = 0; k < 32 && mask[c]; k++) begin
        e = 2'b00;
        b = k >= lat && ((c == 2) ? ~bits[k-lat] & (k - lat > 3) : bits[k-lat]);
        // Dual rail with negative rail held high: zeros pulse negative
        if (!host && !sr[c]) begin
          e = {1'b0, ~b};
        end else if (b) begin
          e = one ? 2'b01 : 2'b10;
          one = ~one;
        end
        `CHK("line pulse", e, obs[c][k])
      end
    end
    $display("test link latency %0d done", lat);
  endtask : run_link

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test

  initial begin
    #200us;
    bad_count++;
    stop_test();
  end

  initial begin
    logic [31:0] r;
    logic e;
    int i;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; host = 1'b1; e3 = 3'h0; sts = 3'h0; sr = 3'h0; jl = 3'h0;
    jh = 3'h0; jtx = 3'h0; neg = 3'h7; bad_count = 0; samples_checked = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    for (i = 0; i < 3; i++) begin
      rd_chk(cca(i), 32'h00);
      rd_chk(jaa(i), 32'h01);
      st_exp[i] = sbyte(3'h0, 5'h01);
    end
    chk_status();
    $display("test reset values done");
    for (i = 0; i < 4; i++) begin
      wr(cca(i % 3), 32'hFFFFFFC0 | cc_t[i]);
      wr(jaa(i % 3), 32'hFFFFFFE0 | ja_t[i]);
      st_exp[i % 3] = sbyte(cc_t[i][2:0], ja_t[i]);
      rd_chk(cca(i % 3), {26'h0, cc_t[i]});
      rd_chk(jaa(i % 3), {27'h0, ja_t[i]});
      chk_status();
    end
    $display("test host table done");
    apb(1'b1, 8'h40, 32'h1, r, e);
    `CHK("unmapped write error", 1'b1, e)
    apb(1'b0, 8'h40, 32'h0, r, e);
    `CHK("unmapped read error", 1'b1, e)
    `CHK("unmapped read data", 32'h0, r)
    apb(1'b1, cca(0) | 8'h01, 32'h0, r, e);
    `CHK("misaligned error", 1'b1, e)
    rd_chk(cca(0), {26'h0, cc_t[3]});
    $display("test refused access done");
    run_link(5'h01, 2, 3'b111);
    run_link(5'h03, JAD + 2, 3'b111);
    host <= 1'b0; e3 <= 3'b100; sts <= 3'b010; sr <= 3'b011;
    jl <= 3'b011; jh <= 3'b100; jtx <= 3'b000;
    repeat (6) @(posedge pclk);
    for (i = 0; i < 3; i++) st_exp[i] = sbyte({e3[i], sts[i], sr[i]}, {2'b00, jh[i], jtx[i], jl[i]});
    chk_status();
    $display("test hardware straps done");
    run_link(5'h01, 2, 3'b111);
    stop_test();
  end
endmodule : tb_top
